/* File: rtl/bit_clock_divider.sv */
// Serial bit clock generator dividing the device clock by 2*(divider+1)
`timescale 1ns/1ps
module bit_clock_divider import sync_serial_pkg::*; #(
   parameter int WIDTH = DIVIDER_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic freeze,
   input wire logic [WIDTH-1:0] divider,
   output logic sclk
);
   // Divider state: half-period counter and clock level
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic level;
   } div_state_t;

   div_state_t state_reg;
   div_state_t state_next;

   generate
      if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
         $error("bit_clock_divider width out of range");
      end
   endgenerate

   // Half period is divider+1 device clocks, so full period is 2*(divider+1)
   always_comb begin
      state_next = state_reg;
      if (!run) begin
         // Idle: clock parks low and the count restarts cleanly
         state_next.count = '0;
         state_next.level = 1'b0;
      end else if (freeze) begin
         // Underrun: level and phase held where they are
         state_next = state_reg;
      end else if (state_reg.count >= divider) begin
         state_next.count = '0;
         state_next.level = ~state_reg.level;
      end else begin
         state_next.count = state_reg.count + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sclk = state_reg.level;
endmodule // bit_clock_divider

/* File: rtl/sync_serial_ctrl.sv */
// Serial port clocking, receive-only counting, interrupt merge and DMA requests
`timescale 1ns/1ps
// Behaviour
// - Bit clock is device clock / 2(divider+1)
// - Divider takes 0..255, resets to zero
// - Receive count is 16-bit software value
// - Receive-only starts after transmit FIFO empties
// - Count received characters, stop at programmed count
// - Receive count upper bits read zero
// - Four enabled sources merge into one interrupt
// - Transmit threshold when level at most threshold
// - Receive threshold when level at least threshold
// - DMA from thresholds only when irq disabled
// - Overrun sticky, cleared by writing zero
// - Underrun sticky, freezes clock and select
module sync_serial_ctrl import sync_serial_pkg::*; #(
   parameter int LEVEL_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic [LEVEL_W-1:0] tx_level,
   input wire logic [LEVEL_W-1:0] rx_level,
   input wire logic rx_char_strobe,
   input wire logic rx_fifo_full,
   output logic serial_bit_clock,
   output logic frame_select_n,
   output logic tx_active,
   output logic rx_only_active,
   output logic dma_tx_req,
   output logic dma_rx_req,
   output logic irq
);
   // Transfer sequencing
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TX,
      ST_UNDERRUN,
      ST_RX_ONLY
   } xfer_state_t;

   // Whole block state
   typedef struct packed {
      logic [7:0] ctrl0;
      logic hold_frame_on_empty;
      logic [THR_W-1:0] tx_thr;
      logic [THR_W-1:0] rx_thr;
      logic [DIVIDER_W-1:0] bit_clock_divider;
      logic [RX_COUNT_W-1:0] receive_count;
      logic [RX_COUNT_W-1:0] rx_counter;
      logic tx_threshold_flag;
      logic rx_threshold_flag;
      logic tx_underrun_flag;
      logic rx_overrun_flag;
      logic [EVT_W-1:0] irq_status;
      logic [EVT_W-1:0] irq_mask;
      xfer_state_t state;
      logic [31:0] rdata;
      logic irq;
      logic dma_tx;
      logic dma_rx;
      logic select_n;
      logic tx_act; // Registered transmit-state decode
      logic rx_act; // Registered receive-only decode
   } ctrl_state_t;

   ctrl_state_t s_reg;
   ctrl_state_t s_next;

   // Helper terms
   logic [LEVEL_W+THR_W-1:0] tx_thr_chars; // threshold in characters
   logic [LEVEL_W+THR_W-1:0] rx_thr_chars;
   logic [LEVEL_W+THR_W-1:0] tx_level_ext;
   logic [LEVEL_W+THR_W-1:0] rx_level_ext;
   logic [RX_COUNT_W-1:0] count_plus;
   logic [EVT_W-1:0] evt_set; // this cycle's interrupt events
   logic underrun_set;
   logic overrun_set;
   logic clk_run;
   logic clk_freeze;

   generate
      if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_level_check
         $error("sync_serial_ctrl level width out of range");
      end
   endgenerate

   // Thresholds count in steps of eight characters
   assign tx_thr_chars = (LEVEL_W + THR_W)'(s_reg.tx_thr) << THR_SCALE_SHIFT;
   assign rx_thr_chars = (LEVEL_W + THR_W)'(s_reg.rx_thr) << THR_SCALE_SHIFT;
   assign tx_level_ext = (LEVEL_W + THR_W)'(tx_level);
   assign rx_level_ext = (LEVEL_W + THR_W)'(rx_level);
   assign count_plus = s_reg.rx_counter + 1'b1;

   // Clock runs only while a frame is open, held during underrun
   assign clk_run = (s_reg.state != ST_IDLE);
   assign clk_freeze = (s_reg.state == ST_UNDERRUN);

   // Next-state logic for registers, flags, sequencing and read port
   always_comb begin
      s_next = s_reg;
      underrun_set = 1'b0;
      // A character arriving into a full FIFO is dropped and flagged
      overrun_set = rx_char_strobe & rx_fifo_full;

      // Level flags follow the FIFO levels every cycle
      s_next.tx_threshold_flag = (tx_level_ext <= tx_thr_chars);
      s_next.rx_threshold_flag = (rx_level_ext >= rx_thr_chars);

      // Transfer sequencer
      case (s_reg.state)
         ST_IDLE: begin
            if (s_reg.ctrl0[PORT_EN_BIT] && tx_level != '0) begin
               s_next.state = ST_TX;
            end
         end
         ST_TX: begin
            if (tx_level == '0) begin
               if (s_reg.hold_frame_on_empty) begin
                  // Frame stays open, wait for the FIFO to refill
                  s_next.state = ST_UNDERRUN;
                  underrun_set = 1'b1;
               end else if (s_reg.ctrl0[RX_AFTER_TX_BIT]) begin
                  // Transmit drained: switch to receive-only
                  s_next.rx_counter = '0;
                  if (s_reg.ctrl0[RX_COUNT_EN_BIT] && s_reg.receive_count == '0) begin
                     s_next.state = ST_IDLE; // nothing to collect
                  end else begin
                     s_next.state = ST_RX_ONLY;
                  end
               end else begin
                  s_next.state = ST_IDLE;
               end
            end
         end
         ST_UNDERRUN: begin
            // Resume once software or DMA refills the FIFO
            if (tx_level != '0) begin
               s_next.state = ST_TX;
            end
         end
         ST_RX_ONLY: begin
            if (rx_char_strobe && !rx_fifo_full) begin
               s_next.rx_counter = count_plus;
               if (s_reg.ctrl0[RX_COUNT_EN_BIT] && count_plus == s_reg.receive_count) begin
                  s_next.state = ST_IDLE;
               end
            end
            // Without counting, software ends the transfer by disabling the port
            if (!s_reg.ctrl0[PORT_EN_BIT]) begin
               s_next.state = ST_IDLE;
            end
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase

      // Source events gated by their enables
      evt_set[EVT_TX_THR] = s_reg.tx_threshold_flag & s_reg.ctrl0[TX_IRQ_EN_BIT];
      evt_set[EVT_RX_THR] = s_reg.rx_threshold_flag & s_reg.ctrl0[RX_IRQ_EN_BIT];
      evt_set[EVT_TX_ERR] = s_reg.tx_underrun_flag & s_reg.ctrl0[TX_ERR_EN_BIT];
      evt_set[EVT_RX_ERR] = s_reg.rx_overrun_flag & s_reg.ctrl0[RX_ERR_EN_BIT];

      // Register writes
      if (wr_en) begin
         case (addr)
            CONTROL_ZERO_OFS: begin
               s_next.ctrl0 = wdata[7:0];
            end
            CONTROL_ONE_OFS: begin
               s_next.hold_frame_on_empty = wdata[HOLD_FRAME_BIT];
               s_next.tx_thr = wdata[TX_THR_LSB +: THR_W];
               s_next.rx_thr = wdata[RX_THR_LSB +: THR_W];
            end
            SERIAL_STATUS_OFS: begin
               // Writing zero clears, writing one
               s_next.tx_underrun_flag = s_reg.tx_underrun_flag & wdata[UNDERRUN_BIT];
               s_next.rx_overrun_flag = s_reg.rx_overrun_flag & wdata[OVERRUN_BIT];
            end
            BIT_CLOCK_DIVIDER_OFS: begin
               s_next.bit_clock_divider = wdata[DIVIDER_W-1:0];
            end
            RECEIVE_COUNT_OFS: begin
               // Upper half is dropped on write
               s_next.receive_count = wdata[RX_COUNT_W-1:0];
            end
            IRQ_STATUS_OFS: begin
               s_next.irq_status = s_reg.irq_status & ~wdata[EVT_W-1:0];
            end
            IRQ_MASK_OFS: begin
               s_next.irq_mask = wdata[EVT_W-1:0];
            end
            default: begin
               s_next.ctrl0 = s_reg.ctrl0;
            end
         endcase
      end

      // Hardware sets come after clears so a coincident event is kept
      if (underrun_set) begin
         s_next.tx_underrun_flag = 1'b1;
      end
      if (overrun_set) begin
         s_next.rx_overrun_flag = 1'b1;
      end
      s_next.irq_status = s_next.irq_status | evt_set;

      // Single level interrupt from unmasked sticky events
      s_next.irq = |(s_next.irq_status & s_next.irq_mask);

      // DMA only from thresholds whose interrupt is disabled
      s_next.dma_tx = s_next.tx_threshold_flag & ~s_reg.ctrl0[TX_IRQ_EN_BIT]
         & s_reg.ctrl0[DMA_EN_BIT];
      s_next.dma_rx = s_next.rx_threshold_flag & ~s_reg.ctrl0[RX_IRQ_EN_BIT]
         & s_reg.ctrl0[DMA_EN_BIT];

      // Select asserted for the whole frame, held through underrun
      s_next.select_n = (s_next.state == ST_IDLE);
      // State decodes kept in flops so no output is a gate after the register
      s_next.tx_act = (s_next.state == ST_TX);
      s_next.rx_act = (s_next.state == ST_RX_ONLY);

      // Read data valid the cycle after the strobe only
      s_next.rdata = 32'h0000_0000;
      if (rd_en) begin
         case (addr)
            CONTROL_ZERO_OFS: begin
               s_next.rdata[7:0] = s_reg.ctrl0;
            end
            CONTROL_ONE_OFS: begin
               s_next.rdata[HOLD_FRAME_BIT] = s_reg.hold_frame_on_empty;
               s_next.rdata[TX_THR_LSB +: THR_W] = s_reg.tx_thr;
               s_next.rdata[RX_THR_LSB +: THR_W] = s_reg.rx_thr;
            end
            SERIAL_STATUS_OFS: begin
               s_next.rdata[TX_LEVEL_LSB +: LEVEL_W] = tx_level;
               s_next.rdata[RX_LEVEL_LSB +: LEVEL_W] = rx_level;
               s_next.rdata[BUSY_BIT] = (s_reg.state != ST_IDLE);
               s_next.rdata[TX_FLAG_BIT] = s_reg.tx_threshold_flag;
               s_next.rdata[RX_FLAG_BIT] = s_reg.rx_threshold_flag;
               s_next.rdata[UNDERRUN_BIT] = s_reg.tx_underrun_flag;
               s_next.rdata[OVERRUN_BIT] = s_reg.rx_overrun_flag;
            end
            BIT_CLOCK_DIVIDER_OFS: begin
               s_next.rdata[DIVIDER_W-1:0] = s_reg.bit_clock_divider;
            end
            RECEIVE_COUNT_OFS: begin
               s_next.rdata[RX_COUNT_W-1:0] = s_reg.receive_count;
            end
            IRQ_STATUS_OFS: begin
               s_next.rdata[EVT_W-1:0] = s_reg.irq_status;
            end
            IRQ_MASK_OFS: begin
               s_next.rdata[EVT_W-1:0] = s_reg.irq_mask;
            end
            default: begin
               // Unmapped addresses read as zero
               s_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // State register, constants only under reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.ctrl0 <= CONTROL_ZERO_RESET;
         s_reg.bit_clock_divider <= DIVIDER_RESET;
         s_reg.receive_count <= RX_COUNT_RESET;
         s_reg.state <= ST_IDLE;
         s_reg.select_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Bit clock generator
   bit_clock_divider #(
      .WIDTH(DIVIDER_W)
   ) u_divider (
      .clk(clk),
      .rst_n(rst_n),
      .run(clk_run),
      .freeze(clk_freeze),
      .divider(s_reg.bit_clock_divider),
      .sclk(serial_bit_clock)
   );

   // Registered outputs
   assign rdata = s_reg.rdata;
   assign irq = s_reg.irq;
   assign dma_tx_req = s_reg.dma_tx;
   assign dma_rx_req = s_reg.dma_rx;
   assign frame_select_n = s_reg.select_n;
   assign tx_active = s_reg.tx_act;
   assign rx_only_active = s_reg.rx_act;
endmodule // sync_serial_ctrl

/* File: rtl/sync_serial_pkg.sv */
// Shared constants for the synchronous serial clock, receive counter and interrupt block
package sync_serial_pkg;
   // Register byte offsets
   localparam logic [7:0] CONTROL_ZERO_OFS = 8'h04;
   localparam logic [7:0] CONTROL_ONE_OFS = 8'h08;
   localparam logic [7:0] SERIAL_STATUS_OFS = 8'h0c;
   localparam logic [7:0] BIT_CLOCK_DIVIDER_OFS = 8'h18;
   localparam logic [7:0] RECEIVE_COUNT_OFS = 8'h1c;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
   // Control register zero fields
   localparam int TX_IRQ_EN_BIT = 0;
   localparam int RX_IRQ_EN_BIT = 1;
   localparam int TX_ERR_EN_BIT = 2;
   localparam int RX_ERR_EN_BIT = 3;
   localparam int DMA_EN_BIT = 4;
   localparam int RX_AFTER_TX_BIT = 5;
   localparam int RX_COUNT_EN_BIT = 6;
   localparam int PORT_EN_BIT = 7;
   // Control register one fields
   localparam int HOLD_FRAME_BIT = 23;
   localparam int TX_THR_LSB = 16;
   localparam int RX_THR_LSB = 8;
   localparam int THR_W = 4;
   localparam int THR_SCALE_SHIFT = 3;
   // Status register fields
   localparam int BUSY_BIT = 6;
   localparam int TX_FLAG_BIT = 3;
   localparam int RX_FLAG_BIT = 2;
   localparam int UNDERRUN_BIT = 1;
   localparam int OVERRUN_BIT = 0;
   localparam int TX_LEVEL_LSB = 16;
   localparam int RX_LEVEL_LSB = 8;
   // Interrupt event bits, same layout in status and mask
   localparam int EVT_TX_THR = 0;
   localparam int EVT_RX_THR = 1;
   localparam int EVT_TX_ERR = 2;
   localparam int EVT_RX_ERR = 3;
   localparam int EVT_W = 4;
   // Field widths and reset values
   localparam int DIVIDER_W = 8;
   localparam int RX_COUNT_W = 16;
   localparam logic [7:0] DIVIDER_RESET = 8'h00;
   localparam logic [15:0] RX_COUNT_RESET = 16'h0000;
   localparam logic [7:0] CONTROL_ZERO_RESET = 8'h00;
endpackage

/* File: tb/serial_peer.sv */
// Model of the far-side serial peripheral: one character per group of bit clock edges
`timescale 1ns/1ps
module serial_peer #(
   parameter int CHAR_BITS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_bit_clock,
   input wire logic frame_select_n,
   output logic char_done
);
   logic sclk_q; // Bit clock seen last cycle
   int bits; // Bits taken in this character
   // Count rising bit clock edges while selected
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         bits <= 0;
         char_done <= 1'b0;
      end else begin
         sclk_q <= serial_bit_clock;
         char_done <= 1'b0;
         if (frame_select_n) begin
            bits <= 0; // Deselect drops a partial character
         end else if (serial_bit_clock && !sclk_q) begin
            if (bits == CHAR_BITS - 1) begin
               bits <= 0;
               char_done <= 1'b1; // One-cycle strobe, as the block expects
            end else begin
               bits <= bits + 1;
            end
         end
      end
   end
endmodule // serial_peer

/* File: tb/sync_serial_ctrl_monitor.sv */
// Port-level checker for the serial clock, receive counter and interrupt block
`timescale 1ns/1ps
module sync_serial_ctrl_monitor import sync_serial_pkg::*; #(
   parameter int LEVEL_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata,
   input wire logic [LEVEL_W-1:0] tx_level,
   input wire logic [LEVEL_W-1:0] rx_level,
   input wire logic rx_char_strobe,
   input wire logic rx_fifo_full,
   input wire logic serial_bit_clock,
   input wire logic frame_select_n,
   input wire logic tx_active,
   input wire logic rx_only_active,
   input wire logic dma_tx_req,
   input wire logic dma_rx_req,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] ctl0_reg; // Shadow of control zero
   logic hold_reg; // Shadow of hold-frame setting
   logic [7:0] div_reg; // Shadow of divider
   logic [15:0] receive_count_reg; // Shadow of receive count
   logic [3:0] mask_reg; // Shadow of interrupt mask
   logic [15:0] got_reg; // Characters taken this run
   logic [9:0] gap_reg; // Clocks since last bit clock change
   logic sclk_q; // Bit clock one cycle back
   logic tog_reg; // An edge already seen in this frame
   wire stalled = !frame_select_n && !tx_active && !rx_only_active; // Frame held by underrun
   // Mirror software writes and count link activity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl0_reg <= 8'h00;
         hold_reg <= 1'b0;
         div_reg <= 8'h00;
         receive_count_reg <= 16'h0000;
         mask_reg <= 4'h0;
         got_reg <= 16'h0000;
         gap_reg <= 10'h000;
         sclk_q <= 1'b0;
         tog_reg <= 1'b0;
      end else begin
         if (wr_en && addr == CONTROL_ZERO_OFS) ctl0_reg <= wdata[7:0];
         if (wr_en && addr == CONTROL_ONE_OFS) hold_reg <= wdata[HOLD_FRAME_BIT];
         if (wr_en && addr == BIT_CLOCK_DIVIDER_OFS) div_reg <= wdata[7:0];
         if (wr_en && addr == RECEIVE_COUNT_OFS) receive_count_reg <= wdata[15:0];
         if (wr_en && addr == IRQ_MASK_OFS) mask_reg <= wdata[3:0];
         // Only strobes inside a receive-only run count
         if (!rx_only_active) got_reg <= 16'h0000;
         else if (rx_char_strobe && !rx_fifo_full) got_reg <= got_reg + 16'h0001;
         sclk_q <= serial_bit_clock;
         // Saturate so a long freeze cannot wrap
         if (serial_bit_clock != sclk_q) gap_reg <= 10'h001;
         else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
         if (frame_select_n) tog_reg <= 1'b0;
         else if (serial_bit_clock != sclk_q) tog_reg <= 1'b1;
      end
   end
   // A freeze only lengthens a half period, hence at least
   sclk_gap_a: assert property (serial_bit_clock != sclk_q && tog_reg && !frame_select_n
      |-> gap_reg >= {2'b00, div_reg} + 10'h001) else $error("bit clock half period too short");
   rx_start_a: assert property ($fell(tx_active) && ctl0_reg[PORT_EN_BIT] && ctl0_reg[RX_AFTER_TX_BIT]
      && !hold_reg && !(ctl0_reg[RX_COUNT_EN_BIT] && receive_count_reg == 16'h0000) |-> rx_only_active)
      else $error("receive-only run did not follow transmit");
   rx_stop_a: assert property (rx_only_active && ctl0_reg[RX_COUNT_EN_BIT] |-> got_reg < receive_count_reg)
      else $error("receive-only run passed its count");
   count_read_a: assert property ($past(rd_en) && $past(addr) == RECEIVE_COUNT_OFS
      |-> rdata == {16'h0000, receive_count_reg}) else $error("receive count read wrong");
   div_read_a: assert property ($past(rd_en) && $past(addr) == BIT_CLOCK_DIVIDER_OFS
      |-> rdata == {24'h000000, div_reg}) else $error("divider read wrong");
   irq_masked_a: assert property (mask_reg == 4'h0 && $past(mask_reg) == 4'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   dma_tx_a: assert property (dma_tx_req |-> $past(ctl0_reg[DMA_EN_BIT] && !ctl0_reg[TX_IRQ_EN_BIT]))
      else $error("transmit request while not allowed");
   dma_rx_a: assert property (dma_rx_req |-> $past(ctl0_reg[DMA_EN_BIT] && !ctl0_reg[RX_IRQ_EN_BIT]))
      else $error("receive request while not allowed");
   underrun_freeze_a: assert property (stalled && $past(stalled) |-> $stable(serial_bit_clock))
      else $error("bit clock moved during underrun");
endmodule // sync_serial_ctrl_monitor
bind sync_serial_ctrl sync_serial_ctrl_monitor #(.LEVEL_W(LEVEL_W)) monitor_i (.clk, .rst_n, .addr, .wdata,
   .wr_en, .rd_en, .rdata, .tx_level, .rx_level, .rx_char_strobe, .rx_fifo_full, .serial_bit_clock,
   .frame_select_n, .tx_active, .rx_only_active, .dma_tx_req, .dma_rx_req, .irq);

/* File: tb/sync_serial_ctrl_tb_top.sv */
// Self-checking bench for the serial clock, receive counter and interrupt block
`timescale 1ns/1ps
module sync_serial_ctrl_tb_top import sync_serial_pkg::*;;
   localparam logic [31:0] PE = 32'h1 << PORT_EN_BIT, RA = 32'h1 << RX_AFTER_TX_BIT,
      CE = 32'h1 << RX_COUNT_EN_BIT, DE = 32'h1 << DMA_EN_BIT, TI = 32'h1 << TX_IRQ_EN_BIT,
      RI = 32'h1 << RX_IRQ_EN_BIT, TE = 32'h1 << TX_ERR_EN_BIT, RE = 32'h1 << RX_ERR_EN_BIT;
   logic clk = 1'b0; // Device clock
   logic rst_n = 1'b0; // Held low at start
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr_en;
   logic rd_en;
   logic [31:0] rdata;
   logic [7:0] tx_level;
   logic [7:0] rx_level;
   logic tb_strobe; // Bench-made strobe for overrun
   logic p_strobe; // Peripheral character strobe
   wire rx_char_strobe = p_strobe | tb_strobe;
   logic rx_fifo_full;
   logic serial_bit_clock, frame_select_n, tx_active, rx_only_active, dma_tx_req, dma_rx_req, irq;
   int num_errors = 0;
   int checked = 0;
   int nstr = 0; // Characters the block should count
   int k, a, b;
   logic s;
   logic [31:0] divs [3] = '{32'h0, 32'h1, 32'h3}; // Divider boundary and small values
   sync_serial_ctrl dut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .tx_level, .rx_level,
      .rx_char_strobe, .rx_fifo_full, .serial_bit_clock, .frame_select_n, .tx_active, .rx_only_active,
      .dma_tx_req, .dma_rx_req, .irq);
   serial_peer #(.CHAR_BITS(4)) peer (.clk, .rst_n, .serial_bit_clock, .frame_select_n, .char_done(p_strobe));
   initial forever #25 clk = ~clk; // Bus and device share one clock, well under four times
   // Mirror the counting the block must do
   always @(posedge clk)
      if (rx_only_active && rx_char_strobe && !rx_fifo_full) nstr++;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rd(input string nm, input logic [7:0] ad, input logic [31:0] m, input logic [31:0] exp);
      @(posedge clk);
      addr <= ad;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(nm, exp, rdata & m);
   endtask
   task lv(input logic [7:0] t, input logic [7:0] r);
      @(posedge clk);
      tx_level <= t;
      rx_level <= r;
   endtask
   task irq_is(input logic e);
      repeat (4) @(posedge clk);
      #1 chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // Bounded wait on receive-only state (sel 0) or bit clock
   task wait_on(input int sel, input logic v, output int n);
      for (n = 1; n < 3000; n++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 ? rx_only_active : serial_bit_clock) === v) return;
      end
      chk("wait bound", 32'h0, 32'h1);
      tally_and_finish();
   endtask
   task tally_and_finish();
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      tx_level = 8'h00;
      rx_level = 8'h00;
      tb_strobe = 1'b0;
      rx_fifo_full = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd("divider", BIT_CLOCK_DIVIDER_OFS, 32'hffffffff, 32'h0);
      rd("rx count", RECEIVE_COUNT_OFS, 32'hffffffff, 32'h0);
      wr(BIT_CLOCK_DIVIDER_OFS, 32'hffffffff);
      rd("divider max", BIT_CLOCK_DIVIDER_OFS, 32'hffffffff, 32'h000000ff);
      wr(RECEIVE_COUNT_OFS, 32'hffffffff);
      rd("rx count top", RECEIVE_COUNT_OFS, 32'hffffffff, 32'h0000ffff);
      rd("unmapped", 8'h3c, 32'hffffffff, 32'h0);
      // Bring-up in order, start bit last
      wr(CONTROL_ZERO_OFS, 32'h0);
      wr(SERIAL_STATUS_OFS, 32'h0);
      wr(CONTROL_ONE_OFS, 32'h00010100);
      wr(RECEIVE_COUNT_OFS, 32'd3);
      lv(8'd5, 8'd0);
      // Full bit clock period for each divider
      for (k = 0; k < 3; k++) begin
         // Drain first: a running frame only ends when the transmit FIFO empties
         lv(8'd0, 8'd0);
         wr(CONTROL_ZERO_OFS, 32'h0);
         wr(BIT_CLOCK_DIVIDER_OFS, divs[k]);
         lv(8'd5, 8'd0);
         wr(CONTROL_ZERO_OFS, PE);
         wait_on(1, 1'b0, a);
         wait_on(1, 1'b1, a);
         wait_on(1, 1'b0, a);
         wait_on(1, 1'b1, b);
         chk("bit clock period", 2 * (divs[k] + 1), a + b);
      end
      wr(CONTROL_ZERO_OFS, PE | RA | CE);
      // Two receive-only runs, the second must count from zero
      for (k = 0; k < 2; k++) begin
         lv(8'd2, 8'd0);
         repeat (3) @(posedge clk);
         nstr = 0;
         lv(8'd0, 8'd0);
         repeat (3) @(posedge clk);
         #1 chk("rx only start", 32'h1, {31'h0, rx_only_active});
         wait_on(0, 1'b0, a);
         chk("chars taken", 32'd3, nstr);
      end
      // Threshold flags at their boundaries and the merged interrupt
      wr(CONTROL_ZERO_OFS, TI | RI | TE | RE);
      wr(IRQ_MASK_OFS, 32'h1);
      lv(8'd8, 8'd0);
      rd("tx flag", SERIAL_STATUS_OFS, 32'hc, 32'h8);
      irq_is(1'b1);
      lv(8'd9, 8'd7);
      rd("no flags", SERIAL_STATUS_OFS, 32'hc, 32'h0);
      wr(IRQ_STATUS_OFS, 32'hf);
      irq_is(1'b0);
      lv(8'd9, 8'd8);
      rd("rx flag", SERIAL_STATUS_OFS, 32'hc, 32'h4);
      wr(IRQ_MASK_OFS, 32'h2);
      irq_is(1'b1);
      wr(IRQ_MASK_OFS, 32'h0);
      irq_is(1'b0);
      // Requests only while the matching interrupt is off
      lv(8'd0, 8'd8);
      for (k = 0; k < 2; k++) begin
         wr(CONTROL_ZERO_OFS, k ? (DE | TI | RI) : DE);
         repeat (4) @(posedge clk);
         #1 chk("dma tx", k ? 32'h0 : 32'h1, {31'h0, dma_tx_req});
         chk("dma rx", k ? 32'h0 : 32'h1, {31'h0, dma_rx_req});
      end
      // Overrun: sticky, write one keeps it, write zero clears
      wr(CONTROL_ZERO_OFS, RE);
      wr(IRQ_MASK_OFS, 32'h8);
      @(posedge clk);
      rx_fifo_full <= 1'b1;
      tb_strobe <= 1'b1;
      @(posedge clk);
      tb_strobe <= 1'b0;
      rx_fifo_full <= 1'b0;
      rd("overrun", SERIAL_STATUS_OFS, 32'h1, 32'h1);
      irq_is(1'b1);
      wr(SERIAL_STATUS_OFS, 32'h1);
      rd("overrun kept", SERIAL_STATUS_OFS, 32'h1, 32'h1);
      wr(SERIAL_STATUS_OFS, 32'h0);
      rd("overrun cleared", SERIAL_STATUS_OFS, 32'h1, 32'h0);
      // Underrun holds the frame until refill
      wr(CONTROL_ZERO_OFS, 32'h0);
      wr(IRQ_STATUS_OFS, 32'hf);
      wr(CONTROL_ONE_OFS, (32'h1 << HOLD_FRAME_BIT) | 32'h00010100);
      wr(IRQ_MASK_OFS, 32'h4);
      lv(8'd3, 8'd0);
      wr(CONTROL_ZERO_OFS, PE | TE);
      repeat (6) @(posedge clk);
      lv(8'd0, 8'd0);
      rd("underrun", SERIAL_STATUS_OFS, 32'h2, 32'h2);
      irq_is(1'b1);
      s = serial_bit_clock;
      repeat (20) @(posedge clk);
      #1 chk("frozen clock", {31'h0, s}, {31'h0, serial_bit_clock});
      chk("select held", 32'h0, {31'h0, frame_select_n});
      lv(8'd1, 8'd0);
      repeat (4) @(posedge clk);
      #1 chk("resumed", 32'h1, {31'h0, tx_active});
      tally_and_finish();
   end
endmodule // sync_serial_ctrl_tb_top
